// [design/channel_volume_mute_control_regs.svh]
// How it works
// - fade bit 7 of fade/mute config enables gradual volume steps; resets to 1
// - bit 1 of fade/mute config mutes the right channel; resets to 0
// - bit 0 of fade/mute config mutes the left channel; resets to 0
// - soft mute keeps blocks running and drives speaker outputs at 50/50 duty
// - all-ones volume code is +24 dB, each lower code half a dB less
// - each volume register resets to 11001111, applied as 0 dB
// - code 00000111 is -100 dB; any lower code mutes the channel
// - left volume is a full 8-bit read/write register at 0x04
// - right volume is an independent 8-bit register at 0x05, same mapping
// - analog config at 0x06: bridge 7, rate 6:4, gain 3:2, source 1, bit 0
// - bridge bit 0 gives two bridged channels, 1 one paralleled mono bridge
// - mono source bit 0 takes right input, 1 takes left input
`ifndef CHANNEL_VOLUME_MUTE_CONTROL_REGS_SVH
`define CHANNEL_VOLUME_MUTE_CONTROL_REGS_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define FADE_MUTE_CFG_OFS   8'h03
`define LEFT_GAIN_OFS       8'h04
`define RIGHT_GAIN_OFS      8'h05
`define ANALOG_CFG_OFS      8'h06

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define FADE_EN_BIT         7
`define MUTE_RIGHT_BIT      1
`define MUTE_LEFT_BIT       0
`define FADE_MUTE_WMASK     8'h83
`define BRIDGE_BIT          7
`define RATE_MSB            6
`define RATE_LSB            4
`define AGAIN_MSB           3
`define AGAIN_LSB           2
`define SOURCE_BIT          1

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define FADE_MUTE_RST       8'h80
`define GAIN_RST            8'hCF
`define ANALOG_RST          8'h51
`define UNITY_CODE          9'h0CF
`define MUTE_BELOW_CODE     8'h07

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS       20
`define FADE_STEP_NS        20480
`define FADE_STEP_CYCLES    (`FADE_STEP_NS / `CLK_PERIOD_NS)

`endif

// [design/channel_volume_mute_control_pkg.sv]
package channel_volume_mute_control_pkg;

    typedef logic [7:0] vol_code_t;
    typedef logic signed [8:0] half_db_t;

    typedef enum logic {
        BRIDGE_STEREO,
        BRIDGE_MONO
    } bridge_mode_e;

endpackage : channel_volume_mute_control_pkg

// [design/channel_volume_mute_control.sv]
`timescale 1ns/100ps
`include "channel_volume_mute_control_regs.svh"

module channel_volume_mute_control #(
    parameter int FADE_STEP_CYCLES = `FADE_STEP_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    output logic      [7:0] left_code_o,
    output logic      [7:0] right_code_o,
    output logic      [8:0] left_half_db_o,
    output logic      [8:0] right_half_db_o,
    output logic            left_mute_o,
    output logic            right_mute_o,
    output logic            spk_a_half_duty_o,
    output logic            spk_b_half_duty_o,
    output logic            spk_a_from_left_o,
    output logic            spk_b_from_left_o,
    output logic            mono_bridge_select_o,
    output logic      [2:0] switch_rate_o,
    output logic      [1:0] analog_gain_o
);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [7:0]                              fade_mute_reg;
    channel_volume_mute_control_pkg::vol_code_t gain_reg [2];
    logic [7:0]                              analog_reg;

    wire sel_cfg    = (reg_addr_i == `FADE_MUTE_CFG_OFS);
    wire sel_left   = (reg_addr_i == `LEFT_GAIN_OFS);
    wire sel_right  = (reg_addr_i == `RIGHT_GAIN_OFS);
    wire sel_analog = (reg_addr_i == `ANALOG_CFG_OFS);

    // reserved bits 6:2 never stored, read back as zero
    wire [7:0] cfg_wval = reg_wdata_i & `FADE_MUTE_WMASK;

    wire [7:0] rd_mux =
        sel_cfg    ? fade_mute_reg :
        sel_left   ? gain_reg[0]   :
        sel_right  ? gain_reg[1]   :
        sel_analog ? analog_reg    : 8'h00;

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    wire wr_cfg    = reg_wr_i & sel_cfg;
    wire wr_left   = reg_wr_i & sel_left;
    wire wr_right  = reg_wr_i & sel_right;
    wire wr_analog = reg_wr_i & sel_analog;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fade_mute_reg <= `FADE_MUTE_RST;
        end else if (wr_cfg) begin
            fade_mute_reg <= cfg_wval;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gain_reg[0] <= `GAIN_RST;
        end else if (wr_left) begin
            gain_reg[0] <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gain_reg[1] <= `GAIN_RST;
        end else if (wr_right) begin
            gain_reg[1] <= reg_wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            analog_reg <= `ANALOG_RST;
        end else if (wr_analog) begin
            analog_reg <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // fade step timer
    // ------------------------------------------------------------------
    localparam int STEP_W = (FADE_STEP_CYCLES > 1) ?
                            $clog2(FADE_STEP_CYCLES) : 1;
    localparam logic [STEP_W-1:0] STEP_LAST =
        STEP_W'(FADE_STEP_CYCLES - 1);

    logic [STEP_W-1:0] fade_cnt_reg;
    wire fade_en   = fade_mute_reg[`FADE_EN_BIT];
    wire fade_tick = (fade_cnt_reg == STEP_LAST);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fade_cnt_reg <= STEP_W'(0);
        end else if (fade_tick) begin
            fade_cnt_reg <= STEP_W'(0);
        end else begin
            fade_cnt_reg <= fade_cnt_reg + STEP_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // per-channel applied volume
    // ------------------------------------------------------------------
    logic [7:0] applied_reg [2];
    logic [8:0] half_db_reg [2];
    logic [1:0] ch_mute_reg;
    wire  [1:0] soft_mute = {fade_mute_reg[`MUTE_RIGHT_BIT],
                             fade_mute_reg[`MUTE_LEFT_BIT]};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            wire       up   = applied_reg[ch] < gain_reg[ch];
            wire       down = applied_reg[ch] > gain_reg[ch];
            wire [7:0] stepped =
                up   ? applied_reg[ch] + 8'h01 :
                down ? applied_reg[ch] - 8'h01 : applied_reg[ch];
            // one code per tick while fading, else jump at once
            wire [7:0] code_next =
                !fade_en  ? gain_reg[ch] :
                fade_tick ? stepped      : applied_reg[ch];
            // half-dB offset from the unity code
            wire [8:0] db_next = {1'b0, code_next} - `UNITY_CODE;
            wire       vol_mute = code_next < `MUTE_BELOW_CODE;

            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    applied_reg[ch] <= `GAIN_RST;
                    half_db_reg[ch] <= 9'h000;
                    ch_mute_reg[ch] <= 1'b0;
                end else begin
                    applied_reg[ch] <= code_next;
                    half_db_reg[ch] <= db_next;
                    ch_mute_reg[ch] <= vol_mute | soft_mute[ch];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // speaker routing
    // ------------------------------------------------------------------
    localparam logic [7:0] ANALOG_INIT = `ANALOG_RST;

    wire mono   = analog_reg[`BRIDGE_BIT] ==
                  channel_volume_mute_control_pkg::BRIDGE_MONO;
    wire src_lf = analog_reg[`SOURCE_BIT];
    wire a_left = mono ? src_lf : 1'b1;
    wire b_left = mono ? src_lf : 1'b0;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spk_a_from_left_o    <= 1'b1;
            spk_b_from_left_o    <= 1'b0;
            mono_bridge_select_o <= ANALOG_INIT[`BRIDGE_BIT];
        end else begin
            spk_a_from_left_o    <= a_left;
            spk_b_from_left_o    <= b_left;
            mono_bridge_select_o <= mono;
        end
    end

    // ------------------------------------------------------------------
    // speaker mute
    // ------------------------------------------------------------------
    wire a_mute = a_left ? ch_mute_reg[0] : ch_mute_reg[1];
    wire b_mute = b_left ? ch_mute_reg[0] : ch_mute_reg[1];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spk_a_half_duty_o <= 1'b0;
            spk_b_half_duty_o <= 1'b0;
        end else begin
            spk_a_half_duty_o <= a_mute;
            spk_b_half_duty_o <= b_mute;
        end
    end

    // ------------------------------------------------------------------
    // analog fields
    // ------------------------------------------------------------------
    wire [2:0] rate_field  = analog_reg[`RATE_MSB:`RATE_LSB];
    wire [1:0] again_field = analog_reg[`AGAIN_MSB:`AGAIN_LSB];

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            switch_rate_o <= ANALOG_INIT[`RATE_MSB:`RATE_LSB];
            analog_gain_o <= ANALOG_INIT[`AGAIN_MSB:`AGAIN_LSB];
        end else begin
            switch_rate_o <= rate_field;
            analog_gain_o <= again_field;
        end
    end

    // ------------------------------------------------------------------
    // volume status outputs
    // ------------------------------------------------------------------
    assign left_code_o     = applied_reg[0];
    assign right_code_o    = applied_reg[1];
    assign left_half_db_o  = half_db_reg[0];
    assign right_half_db_o = half_db_reg[1];
    assign left_mute_o     = ch_mute_reg[0];
    assign right_mute_o    = ch_mute_reg[1];

endmodule : channel_volume_mute_control

// [verif/vol_chk_sva.sv]
`timescale 1ns/100ps
module vol_chk (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic [7:0] left_code_o,
    input  wire logic [7:0] right_code_o,
    input  wire logic [8:0] left_half_db_o,
    input  wire logic [8:0] right_half_db_o,
    input  wire logic       left_mute_o,
    input  wire logic       right_mute_o,
    input  wire logic       mono_bridge_select_o,
    input  wire logic       spk_a_half_duty_o,
    input  wire logic       spk_b_half_duty_o,
    input  wire logic       spk_a_from_left_o,
    input  wire logic       spk_b_from_left_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic fade_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) fade_reg <= 1'b1;
        else if (reg_wr_i && reg_addr_i == 8'h03) fade_reg <= reg_wdata_i[7];
    end
    sequence left_wr_s;
        reg_wr_i && reg_addr_i == 8'h04 && !fade_reg;
    endsequence
    direct_apply_a: assert property (left_wr_s |=> ##1
        left_code_o == $past(reg_wdata_i, 2)) else $error("code");
    left_map_a: assert property (
        left_half_db_o == 9'(left_code_o) - 9'h0CF) else $error("map");
    right_map_a: assert property (
        right_half_db_o == 9'(right_code_o) - 9'h0CF) else $error("map");
    low_mute_a: assert property ((left_code_o >= 8'h07 || left_mute_o)
        && (right_code_o >= 8'h07 || right_mute_o)) else $error("mute");
    half_duty_a: assert property (spk_a_half_duty_o ==
        (spk_a_from_left_o ? $past(left_mute_o) : $past(right_mute_o)))
        else $error("duty");
    duty_b_a: assert property (spk_b_half_duty_o ==
        (spk_b_from_left_o ? $past(left_mute_o) : $past(right_mute_o)))
        else $error("duty b");
    stereo_src_a: assert property (!mono_bridge_select_o |->
        spk_a_from_left_o && !spk_b_from_left_o) else $error("src");
    mono_src_a: assert property (mono_bridge_select_o |->
        spk_a_from_left_o == spk_b_from_left_o) else $error("src");
    rsvd_read_a: assert property (reg_rd_i && reg_addr_i == 8'h03 |=>
        reg_rdata_o[6:2] == 5'h00) else $error("rsvd");
endmodule : vol_chk

bind channel_volume_mute_control vol_chk chk_i (.*);

// [verif/reg_host.sv]
`timescale 1ns/100ps
module reg_host (
    input  wire logic       clk_i,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial begin
        {addr_o, wdata_o, wr_o, rd_o} = 18'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= (a == 8'h03) ? (d & 8'h83) : d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge clk_i);
        {addr_o, wdata_o, wr_o, rd_o} <= {~a, ~d, 2'h0};
    endtask : xfer
endmodule : reg_host

// [verif/tb_channel_volume_mute_control.sv]
`timescale 1ns/100ps
module tb_channel_volume_mute_control;
    logic clk_i = 1'b0, nrst_i = 1'b0, reg_wr_i, reg_rd_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [7:0] left_code_o, right_code_o;
    logic [8:0] left_half_db_o, right_half_db_o;
    logic left_mute_o, right_mute_o, mono_bridge_select_o;
    logic spk_a_half_duty_o, spk_b_half_duty_o;
    logic spk_a_from_left_o, spk_b_from_left_o;
    logic [2:0] switch_rate_o;
    logic [1:0] analog_gain_o;
    int err_total = 0, checks = 0;
    logic [7:0] m [8] = '{8'h0, 8'h0, 8'h0, 8'h80, 8'hCF, 8'hCF,
        8'h51, 8'h0};
    logic [7:0] cs [6] = '{8'hFF, 8'hFE, 8'hCF, 8'h07, 8'h06, 8'h00};
    always #10 clk_i = ~clk_i;
    reg_host h (.clk_i, .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
        .wr_o(reg_wr_i), .rd_o(reg_rd_i));
    channel_volume_mute_control #(.FADE_STEP_CYCLES(4)) dut (.*);
    task automatic chk(input logic [8:0] g, e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task automatic wrm(input logic [7:0] a, d);
        h.xfer(1'b1, a, d);
        if (a >= 8'h03 && a <= 8'h06) m[a[2:0]] = a == 8'h03 ? d & 8'h83 : d;
    endtask : wrm
    task automatic rdc(input logic [7:0] a);
        h.xfer(1'b0, a, 8'h00);
        #1 chk({1'b0, reg_rdata_o}, {1'b0, m[a[2:0]]});
    endtask : rdc
    task automatic expect_all;
        logic lm, rm, mo, fa, fb;
        lm = m[3][0] | (m[4] < 8'h07);
        rm = m[3][1] | (m[5] < 8'h07);
        mo = m[6][7];
        fa = mo ? m[6][1] : 1'b1;
        fb = mo & m[6][1];
        chk(9'(left_code_o), 9'(m[4]));
        chk(9'(right_code_o), 9'(m[5]));
        chk(left_half_db_o, 9'(m[4]) - 9'h0CF);
        chk(right_half_db_o, 9'(m[5]) - 9'h0CF);
        chk({left_mute_o, right_mute_o}, {lm, rm});
        chk({spk_a_half_duty_o, spk_b_half_duty_o},
            {fa ? lm : rm, fb ? lm : rm});
        chk({spk_a_from_left_o, spk_b_from_left_o, mono_bridge_select_o},
            {fa, fb, mo});
        chk({switch_rate_o, analog_gain_o}, m[6][6:2]);
    endtask : expect_all
    initial begin
        void'($urandom(17));
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++) rdc(8'(i));
        expect_all;
        for (int i = 0; i < 16; i++) begin
            wrm(8'h03, 8'(i) & 8'h03);
            wrm(8'h04, i < 6 ? cs[i] : 8'($urandom));
            wrm(8'h05, 8'($urandom));
            wrm(8'h06, {i[3], 5'($urandom), i[2], 1'b1});
            wrm(8'($urandom_range(7)), 8'($urandom) & 8'h7F);
            rdc(8'($urandom_range(7)));
            repeat (3) @(posedge clk_i);
            #1 expect_all;
        end
        wrm(8'h04, 8'h10);
        wrm(8'h03, 8'h80);
        wrm(8'h04, 8'h14);
        @(posedge clk_i);
        #1 chk({8'h00, left_code_o == 8'h14}, 9'h000);
        chk(9'(left_code_o <= 8'h11), 9'h001);
        repeat (5) @(posedge clk_i);
        #1 chk(9'(left_code_o > 8'h10 && left_code_o < 8'h13), 9'h001);
        repeat (30) @(posedge clk_i);
        #1 expect_all;
        report_and_stop;
    end
    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end
endmodule : tb_channel_volume_mute_control
